/* File: src/eeim_pkg.sv */
// Shared constants and types for the energy event interrupt mask block
package eeim_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [29:0] IDX_EVENT_IRQ_ENABLE_FIRST = 30'h0000E50A;
    localparam logic [29:0] IDX_STATUS0 = 30'h0000E600;
    localparam logic [29:0] IDX_PULSE_CFG = 30'h0000E610;
    localparam logic [29:0] IDX_HALF_CYC = 30'h0000E611;
    localparam logic [29:0] IDX_LINE_CTRL = 30'h0000E612;

    // Event bit positions, shared by mask and status
    localparam int EV_ACT_ENERGY = 0;
    localparam int EV_REACT_ENERGY = 2;
    localparam int EV_APP_ENERGY = 4;
    localparam int EV_LINE_DONE = 5;
    localparam int EV_ACT_SIGN_A = 6;
    localparam int EV_PATH1_SIGN = 9;
    localparam int EV_REACT_SIGN_A = 10;
    localparam int EV_PATH2_SIGN = 13;
    localparam int EV_PULSE_ONE = 14;
    localparam int EV_DSP_DONE = 17;
    localparam int EV_PATH3_SIGN = 18;

    localparam logic [31:0] MASK_DEFINED = 32'h0007FFF5;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [31:0] STATUS_RESET = 32'h00000000;

    // Pulse configuration layout
    localparam int PULSE_SEL_BASE = 0;
    localparam int PULSE_SEL_W = 3;
    localparam int PULSE_DIS_BASE = 9;
    localparam int PULSE_CFG_W = 12;
    localparam logic [PULSE_CFG_W-1:0] PULSE_CFG_RESET = 12'h000;

    // Line-cycle accumulation
    localparam int HALF_CYC_W = 16;
    localparam logic [HALF_CYC_W-1:0] HALF_CYC_RESET = 16'h00FF;
    localparam int LINE_MODE_BIT = 0;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int PULSE_LOW_NS = 200;
    localparam int PULSE_LOW_CYC_I =
        (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W = 8;
    localparam logic [PULSE_CNT_W-1:0] PULSE_LOW_CYC =
        PULSE_CNT_W'(PULSE_LOW_CYC_I);

    localparam int NUM_PHASE = 3;
    localparam int NUM_PULSE = 3;
    localparam int NUM_POWER_TYPE = 8;

    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b01,
        PULSE_LOW = 2'b10
    } eeim_pulse_e;

    // Measurement events fed in from the metering datapath
    typedef struct packed {
        logic [NUM_PHASE-1:0] actEnergyMsb;
        logic [NUM_PHASE-1:0] reactEnergyMsb;
        logic [NUM_PHASE-1:0] appEnergyMsb;
        logic [NUM_PHASE-1:0] actSign;
        logic [NUM_PHASE-1:0] reactSign;
        logic [NUM_PULSE-1:0] pathSumSign;
        logic halfCycleTick;
        logic dspDone;
        logic [NUM_POWER_TYPE-1:0] powerPulseReq;
    } eeim_meter_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } eeim_wbreq_s;

endpackage

/* File: src/eeim_change_det.sv */
// Per-bit change and falling-edge detector with a priming cycle
`timescale 1ns/1ns
module eeim_change_det #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] sig,
    output logic [W-1:0] changed,
    output logic [W-1:0] fell
);
    import eeim_pkg::*;

    logic primed;
    logic [W-1:0] prev;

    // First sample after reset only primes the history, no event
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            primed <= 1'b0;
            prev <= '0;
        end else begin
            primed <= 1'b1;
            prev <= sig;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign changed[i] = primed & (sig[i] ^ prev[i]);
            assign fell[i] = primed & prev[i] & ~sig[i];
        end
    endgenerate
endmodule

/* File: src/energy_event_irq_event_irq_enable_first.sv */
// Event interrupt mask, status, pulse outputs and line-cycle timer
//
// Operation
// - Mask bit 0: active energy bit-30 change
// - Mask bit 2: reactive energy bit-30 change
// - Mask bit 4: apparent energy bit-30 change
// - Mask bit 5: line-cycle integration end
// - Mask bits 6-8: phase active power sign
// - Mask bits 10-12: phase reactive power sign
// - Mask bits 9,13,18: pulse path sum sign
// - Mask bits 14-16: pulse output falling edge
// - Pulse interrupts still raised when output disabled
// - Pulse select fields pick each output's power
// - Mask bit 17: periodic DSP computation done
// - Bits 1,3,31-19 unused; enables reset zero
// - Status flag set on event, held until a status read
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
module energy_event_irq_event_irq_enable_first (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire eeim_pkg::eeim_meter_s meter,
    output logic pulseOutOneN,
    output logic pulseOutTwoN,
    output logic pulseOutThreeN,
    output logic irqOutFirstN
);
    import eeim_pkg::*;

    // Register state
    logic [31:0] eventIrqEnableFirst;
    logic [31:0] eventStatus;
    logic [PULSE_CFG_W-1:0] pulseOutputConfig;
    logic [HALF_CYC_W-1:0] halfCycleCount;
    logic lineCycleMode;

    // Bus decode
    eeim_wbreq_s req;
    logic busReq;
    logic [29:0] wordIdx;
    logic hitMask;
    logic hitStatus;
    logic hitPulseCfg;
    logic hitHalfCyc;
    logic hitLineCtrl;
    logic wrStrobe;
    logic rdStrobe;
    logic [31:0] byteMask;
    logic [31:0] rdMux;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign busReq = req.cyc & req.stb & ~wb_ack_o;
    assign wordIdx = req.adr[31:2];
    assign hitMask = (wordIdx == IDX_EVENT_IRQ_ENABLE_FIRST);
    assign hitStatus = (wordIdx == IDX_STATUS0);
    assign hitPulseCfg = (wordIdx == IDX_PULSE_CFG);
    assign hitHalfCyc = (wordIdx == IDX_HALF_CYC);
    assign hitLineCtrl = (wordIdx == IDX_LINE_CTRL);
    assign wrStrobe = busReq & req.we;
    assign rdStrobe = busReq & ~req.we;
    assign byteMask = {{8{req.sel[3]}}, {8{req.sel[2]}},
                       {8{req.sel[1]}}, {8{req.sel[0]}}};

    // Narrow registers widened to the bus word
    logic [31:0] cfgWord;
    logic [31:0] halfWord;
    logic [31:0] ctrlWord;

    assign cfgWord = {{(32-PULSE_CFG_W){1'b0}}, pulseOutputConfig};
    assign halfWord = {{(32-HALF_CYC_W){1'b0}}, halfCycleCount};
    assign ctrlWord = {31'h00000000, lineCycleMode};

    // Unmapped words read zero and ignore writes
    assign rdMux =
        hitMask ? eventIrqEnableFirst :
        hitStatus ? eventStatus :
        hitPulseCfg ? cfgWord :
        hitHalfCyc ? halfWord :
        hitLineCtrl ? ctrlWord :
        32'h00000000;

    // Masked write values
    logic [31:0] next_mask;
    logic [31:0] cfgMerged;
    logic [31:0] halfMerged;
    logic [31:0] ctrlMerged;

    assign next_mask = ((eventIrqEnableFirst & ~byteMask)
                       | (req.dat & byteMask)) & MASK_DEFINED;
    assign cfgMerged = ({{(32-PULSE_CFG_W){1'b0}}, pulseOutputConfig}
                       & ~byteMask) | (req.dat & byteMask);
    assign halfMerged = ({{(32-HALF_CYC_W){1'b0}}, halfCycleCount}
                        & ~byteMask) | (req.dat & byteMask);
    assign ctrlMerged = ({31'h00000000, lineCycleMode} & ~byteMask)
                        | (req.dat & byteMask);

    // Bus answer one cycle after the request is seen
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            if (rdStrobe) begin
                wb_dat_o <= rdMux;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eventIrqEnableFirst <= MASK_RESET;
            pulseOutputConfig <= PULSE_CFG_RESET;
            halfCycleCount <= HALF_CYC_RESET;
            lineCycleMode <= 1'b0;
        end else if (wrStrobe) begin
            if (hitMask) begin
                eventIrqEnableFirst <= next_mask;
            end
            if (hitPulseCfg) begin
                pulseOutputConfig <= cfgMerged[PULSE_CFG_W-1:0];
            end
            if (hitHalfCyc) begin
                halfCycleCount <= halfMerged[HALF_CYC_W-1:0];
            end
            if (hitLineCtrl) begin
                lineCycleMode <= ctrlMerged[LINE_MODE_BIT];
            end
        end
    end

    // Line-cycle accumulation timer
    logic [HALF_CYC_W-1:0] halfCycCnt;
    logic [HALF_CYC_W-1:0] next_halfCycCnt;
    logic lineDoneHit;
    logic lineDone;

    assign lineDoneHit = lineCycleMode & meter.halfCycleTick
                         & (halfCycleCount != '0)
                         & (halfCycCnt == halfCycleCount - 1'b1);
    assign next_halfCycCnt = halfCycCnt + 1'b1;

    // A zero count never completes an integration
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            halfCycCnt <= '0;
            lineDone <= 1'b0;
        end else begin
            lineDone <= lineDoneHit;
            if (!lineCycleMode || (wrStrobe && hitHalfCyc)) begin
                halfCycCnt <= '0;
            end else if (lineDoneHit) begin
                halfCycCnt <= '0;
            end else if (meter.halfCycleTick) begin
                halfCycCnt <= next_halfCycCnt;
            end
        end
    end

    // Pulse outputs: internal active-low level per output
    eeim_pulse_e pulseState [NUM_PULSE];
    logic [PULSE_CNT_W-1:0] pulseCnt [NUM_PULSE];
    logic [NUM_PULSE-1:0] pulseLevelN;
    logic [NUM_PULSE-1:0] pulseDisable;
    logic [NUM_PULSE-1:0] pulseSrc;
    logic [NUM_PULSE-1:0] pinLevelN;

    genvar p;
    generate
        for (p = 0; p < NUM_PULSE; p++) begin : g_pulse
            logic [PULSE_SEL_W-1:0] selField;
            assign selField = pulseOutputConfig[PULSE_SEL_BASE
                              + p*PULSE_SEL_W +: PULSE_SEL_W];
            assign pulseSrc[p] = meter.powerPulseReq[selField];
            assign pulseDisable[p] = pulseOutputConfig[PULSE_DIS_BASE + p];
            assign pulseLevelN[p] = (pulseState[p] != PULSE_LOW);

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    pulseState[p] <= PULSE_IDLE;
                    pulseCnt[p] <= '0;
                end else begin
                    case (pulseState[p])
                        PULSE_IDLE: begin
                            if (pulseSrc[p]) begin
                                pulseState[p] <= PULSE_LOW;
                                pulseCnt[p] <= PULSE_LOW_CYC - 1'b1;
                            end
                        end
                        PULSE_LOW: begin
                            if (pulseCnt[p] == '0) begin
                                pulseState[p] <= PULSE_IDLE;
                            end else begin
                                pulseCnt[p] <= pulseCnt[p] - 1'b1;
                            end
                        end
                        default: begin
                            pulseState[p] <= PULSE_IDLE;
                            pulseCnt[p] <= '0;
                        end
                    endcase
                end
            end

            // Disable only holds the pin high; internal pulse still runs
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    pinLevelN[p] <= 1'b1;
                end else begin
                    pinLevelN[p] <= pulseLevelN[p] | pulseDisable[p];
                end
            end
        end
    endgenerate

    assign pulseOutOneN = pinLevelN[0];
    assign pulseOutTwoN = pinLevelN[1];
    assign pulseOutThreeN = pinLevelN[2];

    // Change and edge detection on the measurement signals
    localparam int DET_W = 5*NUM_PHASE + 2*NUM_PULSE;
    logic [DET_W-1:0] detIn;
    logic [DET_W-1:0] detChanged;
    logic [DET_W-1:0] detFell;

    // Pulse level on top; only its falling edges become events
    assign detIn = {pulseLevelN, meter.pathSumSign, meter.reactSign,
                    meter.actSign, meter.appEnergyMsb, meter.actEnergyMsb,
                    meter.reactEnergyMsb};

    eeim_change_det #(
        .W(DET_W)
    ) u_det (
        .sys_clk(sys_clk),
        .rst(rst),
        .sig(detIn),
        .changed(detChanged),
        .fell(detFell)
    );

    // Slice views of the detector outputs
    logic [NUM_PHASE-1:0] chReactEnergy;
    logic [NUM_PHASE-1:0] chActEnergy;
    logic [NUM_PHASE-1:0] chAppEnergy;
    logic [NUM_PHASE-1:0] chActSign;
    logic [NUM_PHASE-1:0] chReactSign;
    logic [NUM_PULSE-1:0] chPathSign;
    logic [NUM_PULSE-1:0] pulseFell;

    assign chReactEnergy = detChanged[0 +: NUM_PHASE];
    assign chActEnergy = detChanged[NUM_PHASE +: NUM_PHASE];
    assign chAppEnergy = detChanged[2*NUM_PHASE +: NUM_PHASE];
    assign chActSign = detChanged[3*NUM_PHASE +: NUM_PHASE];
    assign chReactSign = detChanged[4*NUM_PHASE +: NUM_PHASE];
    assign chPathSign = detChanged[5*NUM_PHASE +: NUM_PULSE];
    assign pulseFell = detFell[DET_W - NUM_PULSE +: NUM_PULSE];

    // Event vector in mask layout
    logic [31:0] eventVec;

    always_comb begin
        eventVec = 32'h00000000;
        eventVec[EV_ACT_ENERGY] = |chActEnergy;
        eventVec[EV_REACT_ENERGY] = |chReactEnergy;
        eventVec[EV_APP_ENERGY] = |chAppEnergy;
        eventVec[EV_LINE_DONE] = lineDone;
        eventVec[EV_ACT_SIGN_A +: NUM_PHASE] = chActSign;
        eventVec[EV_REACT_SIGN_A +: NUM_PHASE] = chReactSign;
        eventVec[EV_PATH1_SIGN] = chPathSign[0];
        eventVec[EV_PATH2_SIGN] = chPathSign[1];
        eventVec[EV_PATH3_SIGN] = chPathSign[2];
        // Taken from the internal level, so disable does not hide it
        eventVec[EV_PULSE_ONE +: NUM_PULSE] = pulseFell;
        eventVec[EV_DSP_DONE] = meter.dspDone;
    end

    // Sticky status, cleared by a read; a same-cycle event wins
    logic statusRead;
    logic [31:0] next_status;

    assign statusRead = rdStrobe & hitStatus;
    assign next_status = (statusRead ? STATUS_RESET : eventStatus)
                         | (eventVec & MASK_DEFINED);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eventStatus <= STATUS_RESET;
        end else begin
            eventStatus <= next_status;
        end
    end

    // Named enable fields; spare mask bits never reach the request
    logic activeEnergyHalfFullEn;
    logic reactiveEnergyHalfFullEn;
    logic apparentEnergyHalfFullEn;
    logic lineCycleDoneEn;
    logic [NUM_PHASE-1:0] phaseActiveSignEn;
    logic [NUM_PHASE-1:0] phaseReactiveSignEn;
    logic pulsePath1SumSignEn;
    logic pulsePath2SumSignEn;
    logic pulsePath3SumSignEn;
    logic [NUM_PULSE-1:0] pulseOutEn;
    logic dspCycleDoneEn;
    logic [31:0] enableVec;
    logic [31:0] pendingVec;

    assign activeEnergyHalfFullEn = eventIrqEnableFirst[EV_ACT_ENERGY];
    assign reactiveEnergyHalfFullEn = eventIrqEnableFirst[EV_REACT_ENERGY];
    assign apparentEnergyHalfFullEn = eventIrqEnableFirst[EV_APP_ENERGY];
    assign lineCycleDoneEn = eventIrqEnableFirst[EV_LINE_DONE];
    assign phaseActiveSignEn =
        eventIrqEnableFirst[EV_ACT_SIGN_A +: NUM_PHASE];
    assign phaseReactiveSignEn =
        eventIrqEnableFirst[EV_REACT_SIGN_A +: NUM_PHASE];
    assign pulsePath1SumSignEn = eventIrqEnableFirst[EV_PATH1_SIGN];
    assign pulsePath2SumSignEn = eventIrqEnableFirst[EV_PATH2_SIGN];
    assign pulsePath3SumSignEn = eventIrqEnableFirst[EV_PATH3_SIGN];
    assign pulseOutEn = eventIrqEnableFirst[EV_PULSE_ONE +: NUM_PULSE];
    assign dspCycleDoneEn = eventIrqEnableFirst[EV_DSP_DONE];

    always_comb begin
        enableVec = 32'h00000000;
        enableVec[EV_ACT_ENERGY] = activeEnergyHalfFullEn;
        enableVec[EV_REACT_ENERGY] = reactiveEnergyHalfFullEn;
        enableVec[EV_APP_ENERGY] = apparentEnergyHalfFullEn;
        enableVec[EV_LINE_DONE] = lineCycleDoneEn;
        enableVec[EV_ACT_SIGN_A +: NUM_PHASE] = phaseActiveSignEn;
        enableVec[EV_REACT_SIGN_A +: NUM_PHASE] = phaseReactiveSignEn;
        enableVec[EV_PATH1_SIGN] = pulsePath1SumSignEn;
        enableVec[EV_PATH2_SIGN] = pulsePath2SumSignEn;
        enableVec[EV_PATH3_SIGN] = pulsePath3SumSignEn;
        enableVec[EV_PULSE_ONE +: NUM_PULSE] = pulseOutEn;
        enableVec[EV_DSP_DONE] = dspCycleDoneEn;
    end

    // Request level follows unmasked flags
    assign pendingVec = eventStatus & enableVec;
    assign irqOutFirstN = ~|pendingVec;

endmodule

/* File: test/eeim_irq_monitor.sv */
// Port-level assertions for the event interrupt mask block
`timescale 1ns/1ns
module eeim_irq_monitor
    import eeim_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire eeim_pkg::eeim_meter_s meter,
    input wire logic pulseOutOneN,
    input wire logic pulseOutTwoN,
    input wire logic irqOutFirstN
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic [29:0] idx = wb_adr_i[31:2];
    wire logic rdAck = wb_ack_o && !wb_we_i;
    wire logic known = idx == IDX_EVENT_IRQ_ENABLE_FIRST || idx == IDX_STATUS0
        || (idx >= IDX_PULSE_CFG && idx <= IDX_LINE_CTRL);

    a_ack_follows_req: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Ack missing after request");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle");
    a_mask_spare_zero: assert property (
        rdAck && idx == IDX_EVENT_IRQ_ENABLE_FIRST |-> (wb_dat_o & ~MASK_DEFINED) == '0)
        else $error("Unused mask bits read nonzero");
    a_unmapped_zero: assert property (
        rdAck && !known |-> wb_dat_o == '0)
        else $error("Unmapped read nonzero");
    a_status_spare_zero: assert property (
        rdAck && idx == IDX_STATUS0 |-> (wb_dat_o & ~MASK_DEFINED) == '0)
        else $error("Unused status bits read nonzero");
    a_irq_release_access: assert property (
        $rose(irqOutFirstN) |-> wb_ack_o)
        else $error("Interrupt released without access");
    a_pulse_has_cause: assert property (
        $fell(pulseOutOneN) || $fell(pulseOutTwoN)
        |-> $past(meter.powerPulseReq, 2) != '0)
        else $error("Pulse without request");
    a_pulse_low_width: assert property (
        $fell(pulseOutOneN) |-> (!pulseOutOneN) [*8] ##1 !pulseOutOneN
        ##1 !pulseOutOneN ##1 pulseOutOneN)
        else $error("Pulse width wrong");
endmodule

bind energy_event_irq_event_irq_enable_first eeim_irq_monitor mon (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .meter(meter), .pulseOutOneN(pulseOutOneN),
    .pulseOutTwoN(pulseOutTwoN), .irqOutFirstN(irqOutFirstN));

/* File: test/energy_event_irq_event_irq_enable_first_bench.sv */
// Self-checking bench for the event interrupt mask block
`timescale 1ns/1ns
module energy_event_irq_event_irq_enable_first_bench;
    import eeim_pkg::*;
    logic sys_clk, rst, wbCyc, wbStb, wbWe, ackO, pOne, pTwo, pThree, irqN;
    logic [31:0] wbAdr, wbDat, datO, rdData;
    logic [3:0] wbSel;
    logic [2:0] pinSnap;
    eeim_meter_s meter, f;
    int badCount = 0;
    int checks = 0;
    int cycles = 0;

    energy_event_irq_event_irq_enable_first dut (.sys_clk(sys_clk), .rst(rst),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
        .wb_dat_o(datO), .wb_ack_o(ackO), .meter(meter),
        .pulseOutOneN(pOne), .pulseOutTwoN(pTwo), .pulseOutThreeN(pThree),
        .irqOutFirstN(irqN));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Whole run needs about 1000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            badCount++;
            closeOut;
        end
    end

    task closeOut;
        if (badCount == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Called just after a rising edge; read data taken at the ack edge
    task wb(input logic w, input logic [29:0] ix, input logic [31:0] d,
            input logic [3:0] s);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= {ix, 2'b00};
        wbSel <= s;
        wbDat <= d;
        do @(posedge sys_clk); while (ackO !== 1'b1);
        rdData = datO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task wr(input logic [29:0] ix, input logic [31:0] d);
        wb(1'b1, ix, d, 4'hF);
    endtask

    task rd(input logic [29:0] ix);
        wb(1'b0, ix, 32'h0, 4'hF);
    endtask

    // Toggles level events, pulses the strobe-type inputs for one cycle
    task apply(input eeim_meter_s fl);
        meter <= meter ^ fl;
        @(posedge sys_clk);
        meter.halfCycleTick <= 1'b0;
        meter.dspDone <= 1'b0;
        meter.powerPulseReq <= '0;
        repeat (2) @(posedge sys_clk);
        pinSnap = {pThree, pTwo, pOne};
    endtask

    // Event once masked, once unmasked; gap outlasts a pulse low time
    task trig(input int b, input eeim_meter_s fl);
        logic [31:0] bv;
        bv = 32'h1 << b;
        wr(IDX_EVENT_IRQ_ENABLE_FIRST, ~bv);
        apply(fl);
        repeat (12) @(posedge sys_clk);
        check("irq masked", irqN, 1'b1);
        rd(IDX_STATUS0);
        check("status", rdData, bv);
        wr(IDX_EVENT_IRQ_ENABLE_FIRST, bv);
        apply(fl);
        repeat (12) @(posedge sys_clk);
        check("irq", irqN, 1'b0);
        rd(IDX_STATUS0);
        check("status again", rdData, bv);
        check("irq cleared", irqN, 1'b1);
    endtask

    task s_regs;
        rd(IDX_EVENT_IRQ_ENABLE_FIRST);
        check("mask reset", rdData, 32'h0);
        rd(IDX_STATUS0);
        check("status reset", rdData, 32'h0);
        check("irq idle", irqN, 1'b1);
        wr(IDX_EVENT_IRQ_ENABLE_FIRST, 32'hFFFFFFFF);
        rd(IDX_EVENT_IRQ_ENABLE_FIRST);
        check("mask bits", rdData, 32'h0007FFF5);
        wb(1'b1, IDX_EVENT_IRQ_ENABLE_FIRST, 32'h0, 4'h1);
        rd(IDX_EVENT_IRQ_ENABLE_FIRST);
        check("mask byte", rdData, 32'h0007FF00);
        rd(IDX_PULSE_CFG);
        check("config reset", rdData, 32'h0);
        rd(IDX_HALF_CYC);
        check("count reset", rdData, 32'h000000FF);
        rd(IDX_LINE_CTRL);
        check("mode reset", rdData, 32'h0);
        rd(30'h00001234);
        check("unmapped", rdData, 32'h0);
    endtask

    task s_events;
        for (int i = 0; i < 3; i++) begin
            f = '0;
            f.actEnergyMsb[i] = 1'b1;
            trig(EV_ACT_ENERGY, f);
            f = '0;
            f.reactEnergyMsb[i] = 1'b1;
            trig(EV_REACT_ENERGY, f);
            f = '0;
            f.appEnergyMsb[i] = 1'b1;
            trig(EV_APP_ENERGY, f);
            f = '0;
            f.actSign[i] = 1'b1;
            trig(EV_ACT_SIGN_A + i, f);
            f = '0;
            f.reactSign[i] = 1'b1;
            trig(EV_REACT_SIGN_A + i, f);
            f = '0;
            f.pathSumSign[i] = 1'b1;
            trig(i == 0 ? 9 : i == 1 ? 13 : 18, f);
        end
        f = '0;
        f.dspDone = 1'b1;
        trig(EV_DSP_DONE, f);
    endtask

    // Outputs pick request lines 5, 6, 7; the third output is disabled
    task s_pulse;
        wr(IDX_PULSE_CFG, 32'h000009F5);
        for (int j = 0; j < 3; j++) begin
            f = '0;
            f.powerPulseReq[5 + j] = 1'b1;
            trig(EV_PULSE_ONE + j, f);
            check("pins", pinSnap,
                  j == 0 ? 3'b110 : j == 1 ? 3'b101 : 3'b111);
        end
    endtask

    task s_line;
        f = '0;
        f.halfCycleTick = 1'b1;
        wr(IDX_EVENT_IRQ_ENABLE_FIRST, 32'h20);
        wr(IDX_HALF_CYC, 32'h3);
        wr(IDX_LINE_CTRL, 32'h1);
        repeat (2) apply(f);
        repeat (4) @(posedge sys_clk);
        check("line early", irqN, 1'b1);
        apply(f);
        repeat (4) @(posedge sys_clk);
        check("line irq", irqN, 1'b0);
        rd(IDX_STATUS0);
        check("line status", rdData, 32'h20);
        wr(IDX_LINE_CTRL, 32'h0);
        repeat (3) apply(f);
        repeat (4) @(posedge sys_clk);
        check("line off", irqN, 1'b1);
    endtask

    initial begin
        rst = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = '0;
        wbDat = '0;
        wbSel = '0;
        meter = '0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        s_regs;
        s_events;
        s_pulse;
        s_line;
        closeOut;
    end
endmodule
